// ==== common/cmim_pkg.sv ====
// Behaviour
// [RL1] bus activity only while controller enabled
// [RL2] low power only after pending transmits finish
// [RL3] listen mode when bit set, else normal
// [RL4] overload frame after good receive when enabled
// [RL5] timestamp at start or end of frame
// [RL6] time triggered scheduling when bit set
// [RL7] timer wraps past maximum when not frozen
// [RL8] frozen timer holds at maximum until reset
// [RL9] lost arbitration keeps request pending
// [RL10] no-repeat aborts, raising abort and ready flags
// [RL11] enable register sets mask bits
// [RL12] disable register clears mask bits
// [RL13] mask register reads current mask
// [RL14] mailbox events at bits 0 to 7
// [RL15] bus-state sources at bits 16 to 23
// [RL16] protocol errors at bits 24 to 28
// [RL17] interrupt when flag set and unmasked
// [RL18] last-mailbox receive resets timer in time-triggered
// [RL19] unassigned interrupt bits ignored, read zero
package cmim_pkg;
   localparam logic [7:0] CMIM_OFS_MODE = 8'h00;
   localparam logic [7:0] CMIM_OFS_IER = 8'h04;
   localparam logic [7:0] CMIM_OFS_IDR = 8'h08;
   localparam logic [7:0] CMIM_OFS_IMR = 8'h0C;
   localparam logic [7:0] CMIM_OFS_SR = 8'h10;
   localparam logic [7:0] CMIM_OFS_TIM = 8'h18;
   localparam logic [7:0] CMIM_OFS_STAMP = 8'h1C;
   // mode register fields
   localparam int CMIM_MR_EN = 0;
   localparam int CMIM_MR_LOWPWR = 1;
   localparam int CMIM_MR_LISTEN = 2;
   localparam int CMIM_MR_OVERLOAD = 3;
   localparam int CMIM_MR_EOFPT = 4;
   localparam int CMIM_MR_TTRIG = 5;
   localparam int CMIM_MR_FRZ = 6;
   localparam int CMIM_MR_NOREP = 7;
   localparam logic [7:0] CMIM_MR_RESET = 8'h00;
   // interrupt source positions
   localparam int CMIM_B_MB0 = 0;
   localparam int CMIM_B_ACTIVE = 16;
   localparam int CMIM_B_WARN = 17;
   localparam int CMIM_B_PASSIVE = 18;
   localparam int CMIM_B_BUSOFF = 19;
   localparam int CMIM_B_SLEEP = 20;
   localparam int CMIM_B_WAKE = 21;
   localparam int CMIM_B_OVF = 22;
   localparam int CMIM_B_STAMP = 23;
   localparam int CMIM_B_CRC = 24;
   localparam logic [31:0] CMIM_IRQ_BITS = 32'h1FFF00FF;
   localparam logic [31:0] CMIM_STICKY_BITS = 32'h1FC000FF;
   localparam logic [31:0] CMIM_IMR_RESET = 32'h00000000;
   localparam logic [15:0] CMIM_TIM_MAX = 16'hFFFF;
   localparam logic [15:0] CMIM_TIM_RESET = 16'h0000;
   localparam logic [2:0] CMIM_LAST_MB = 3'h7;
   localparam logic [1:0] CMIM_RESP_OKAY = 2'h0;
   localparam logic [1:0] CMIM_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0]
   {
      CMIM_PWR_RUN = 2'b00,
      CMIM_PWR_DRAIN = 2'b01,
      CMIM_PWR_SLEEP = 2'b10
   } cmim_pwr_e;
endpackage : cmim_pkg

// ==== hdl/cmim_ctrl.sv ====
module cmim_ctrl
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // protocol engine side, same clock
   input wire logic timer_tick,
   input wire logic sof_seen,
   input wire logic eof_seen,
   input wire logic tx_pending,
   input wire logic rx_done,
   input wire logic [2:0] rx_mailbox,
   input wire logic rx_mailbox_is_rx,
   input wire logic arb_lost,
   input wire logic [2:0] arb_mailbox,
   input wire logic [7:0] mailbox_event_bit,
   input wire logic error_active_source,
   input wire logic warning_limit_source,
   input wire logic error_passive_source,
   input wire logic bus_off_source,
   input wire logic [4:0] protocol_error_pulse,
   output logic bus_active,
   output logic listen_mode,
   output logic time_triggered_mode,
   output logic mailbox_timestamp_on,
   output logic overload_request,
   output logic [7:0] mailbox_abort_flag,
   output logic [7:0] mailbox_ready_flag,
   output logic [7:0] retry_keep,
   output logic [15:0] running_timer,
   output logic [15:0] timestamp_register,
   output logic irq
);
   // byte strobe to bit mask, shared by every writable register
   function automatic logic [31:0] cmim_strb_mask(input logic [3:0] strb);
      cmim_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}},
                        {8{strb[0]}}};
   endfunction : cmim_strb_mask

   logic [7:0] mode_reg;
   logic [31:0] imr_reg;
   logic [31:0] sticky_reg;
   logic [31:0] sticky_next;
   logic [15:0] timer_reg;
   logic [15:0] stamp_reg;
   cmim_pkg::cmim_pwr_e pwr_reg;
   cmim_pkg::cmim_pwr_e pwr_next;
   logic ovld_reg;
   logic [7:0] abort_reg;
   logic [7:0] keep_reg;
   logic irq_reg;

   // write and read channel holding registers
   logic aw_held_reg;
   logic [7:0] aw_addr_reg;
   logic w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;

   wire en = mode_reg[cmim_pkg::CMIM_MR_EN];
   wire lowpwr = mode_reg[cmim_pkg::CMIM_MR_LOWPWR];
   wire eof_point = mode_reg[cmim_pkg::CMIM_MR_EOFPT];
   wire ttrig = mode_reg[cmim_pkg::CMIM_MR_TTRIG];
   wire frz = mode_reg[cmim_pkg::CMIM_MR_FRZ];
   wire norep = mode_reg[cmim_pkg::CMIM_MR_NOREP];
   wire sleeping = (pwr_reg == cmim_pkg::CMIM_PWR_SLEEP);

   // bus handshakes
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   wire [31:0] wmask = cmim_strb_mask(w_strb_reg);
   wire [31:0] wbits = w_data_reg & wmask;

   // address decode
   wire wr_mode = do_write && (aw_addr_reg == cmim_pkg::CMIM_OFS_MODE);
   wire wr_ier = do_write && (aw_addr_reg == cmim_pkg::CMIM_OFS_IER);
   wire wr_idr = do_write && (aw_addr_reg == cmim_pkg::CMIM_OFS_IDR);
   wire wr_ok = wr_mode || wr_ier || wr_idr;
   wire rd_sr = ar_hs && (s_axi_araddr == cmim_pkg::CMIM_OFS_SR);
   logic [31:0] rd_value;
   logic rd_hit;
   wire [31:0] sr_view;

   // mask register: enable-set and enable-clear never share a write
   wire [31:0] imr_set = wr_ier ? wbits : 32'h00000000; // RL11
   wire [31:0] imr_clr = wr_idr ? wbits : 32'h00000000; // RL12
   wire [31:0] imr_next = ((imr_reg | imr_set) & ~imr_clr)
                          & cmim_pkg::CMIM_IRQ_BITS; // RL19
   wire [7:0] mode_next = (mode_reg & ~wmask[7:0])
                          | (w_data_reg[7:0] & wmask[7:0]);

   // timer
   wire tt_sync = ttrig && rx_done
                  && (rx_mailbox == cmim_pkg::CMIM_LAST_MB); // RL18
   wire at_max = (timer_reg == cmim_pkg::CMIM_TIM_MAX);
   wire tick_on = en && timer_tick;
   wire ovf_hit = tick_on && at_max && !tt_sync;
   logic [15:0] timer_next;
   always_comb
   begin
      timer_next = timer_reg;
      if (!en)
         timer_next = cmim_pkg::CMIM_TIM_RESET;
      else if (tt_sync)
         timer_next = cmim_pkg::CMIM_TIM_RESET; // RL18
      else if (tick_on && !(frz && at_max)) // RL8
         timer_next = timer_reg + 16'h0001; // RL7
   end
   wire ts_hit = en && (eof_point ? eof_seen : sof_seen); // RL5

   // low power sequencing
   always_comb
   begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         cmim_pkg::CMIM_PWR_RUN:
            if (en && lowpwr)
               pwr_next = cmim_pkg::CMIM_PWR_DRAIN;
         cmim_pkg::CMIM_PWR_DRAIN:
            if (!en || !lowpwr)
               pwr_next = cmim_pkg::CMIM_PWR_RUN;
            else if (!tx_pending)
               pwr_next = cmim_pkg::CMIM_PWR_SLEEP; // RL2
         cmim_pkg::CMIM_PWR_SLEEP:
            if (!en || !lowpwr)
               pwr_next = cmim_pkg::CMIM_PWR_RUN;
         default:
            pwr_next = cmim_pkg::CMIM_PWR_RUN;
      endcase
   end

   // status: sticky events plus live levels
   logic [31:0] ev_set;
   always_comb
   begin
      ev_set = 32'h00000000;
      ev_set[cmim_pkg::CMIM_B_MB0 +: 8] = mailbox_event_bit; // RL14
      ev_set[cmim_pkg::CMIM_B_OVF] = ovf_hit; // RL15
      ev_set[cmim_pkg::CMIM_B_STAMP] = ts_hit; // RL15
      ev_set[cmim_pkg::CMIM_B_CRC +: 5] = protocol_error_pulse; // RL16
   end
   // set wins over read clear
   assign sticky_next = ((sticky_reg & ~(rd_sr ? 32'hFFFFFFFF
                          : 32'h00000000)) | ev_set)
                        & cmim_pkg::CMIM_STICKY_BITS;
   logic [31:0] level_bits;
   always_comb
   begin
      level_bits = 32'h00000000;
      level_bits[cmim_pkg::CMIM_B_ACTIVE] = error_active_source; // RL15
      level_bits[cmim_pkg::CMIM_B_WARN] = warning_limit_source;
      level_bits[cmim_pkg::CMIM_B_PASSIVE] = error_passive_source;
      level_bits[cmim_pkg::CMIM_B_BUSOFF] = bus_off_source;
      level_bits[cmim_pkg::CMIM_B_SLEEP] = sleeping;
      level_bits[cmim_pkg::CMIM_B_WAKE] = en && !sleeping;
   end
   assign sr_view = sticky_reg | level_bits;
   wire irq_next = |(sr_view & imr_reg); // RL17

   // read mux
   always_comb
   begin
      rd_value = 32'h00000000;
      rd_hit = 1'b1;
      if (s_axi_araddr == cmim_pkg::CMIM_OFS_MODE)
         rd_value = {24'h000000, mode_reg};
      else if (s_axi_araddr == cmim_pkg::CMIM_OFS_IMR)
         rd_value = imr_reg; // RL13
      else if (s_axi_araddr == cmim_pkg::CMIM_OFS_SR)
         rd_value = sr_view;
      else if (s_axi_araddr == cmim_pkg::CMIM_OFS_TIM)
         rd_value = {16'h0000, timer_reg};
      else if (s_axi_araddr == cmim_pkg::CMIM_OFS_STAMP)
         rd_value = {16'h0000, stamp_reg};
      else
         rd_hit = 1'b0;
   end

   // arbitration loss handling
   wire [7:0] arb_onehot = arb_lost && en
                           ? (8'h01 << arb_mailbox) : 8'h00;
   wire [7:0] abort_next = norep ? arb_onehot : 8'h00; // RL10
   wire [7:0] keep_next = norep ? 8'h00 : arb_onehot; // RL9
   wire ovld_next = mode_reg[cmim_pkg::CMIM_MR_OVERLOAD] && en
                   && rx_done && rx_mailbox_is_rx; // RL4

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= cmim_pkg::CMIM_RESP_OKAY;
      end
      else
      begin
         if (aw_hs)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held_reg <= 1'b0;
         if (w_hs)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         else if (do_write)
            w_held_reg <= 1'b0;
         if (do_write)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? cmim_pkg::CMIM_RESP_OKAY
                         : cmim_pkg::CMIM_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= cmim_pkg::CMIM_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_value;
         rresp_reg <= rd_hit ? cmim_pkg::CMIM_RESP_OKAY
                      : cmim_pkg::CMIM_RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_reg <= cmim_pkg::CMIM_MR_RESET;
         imr_reg <= cmim_pkg::CMIM_IMR_RESET;
         sticky_reg <= 32'h00000000;
         timer_reg <= cmim_pkg::CMIM_TIM_RESET;
         stamp_reg <= cmim_pkg::CMIM_TIM_RESET;
         pwr_reg <= cmim_pkg::CMIM_PWR_RUN;
         ovld_reg <= 1'b0;
         abort_reg <= 8'h00;
         keep_reg <= 8'h00;
         irq_reg <= 1'b0;
      end
      else
      begin
         if (wr_mode)
            mode_reg <= mode_next;
         imr_reg <= imr_next;
         sticky_reg <= sticky_next;
         timer_reg <= timer_next;
         if (ts_hit)
            stamp_reg <= timer_reg; // RL5
         pwr_reg <= pwr_next;
         ovld_reg <= ovld_next;
         abort_reg <= abort_next;
         keep_reg <= keep_next;
         irq_reg <= irq_next;
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign bus_active = en && !sleeping; // RL1
   assign listen_mode = en && mode_reg[cmim_pkg::CMIM_MR_LISTEN]; // RL3
   assign time_triggered_mode = en && ttrig; // RL6
   assign mailbox_timestamp_on = en && !ttrig; // RL6
   assign overload_request = ovld_reg;
   assign mailbox_abort_flag = abort_reg; // RL10
   assign mailbox_ready_flag = abort_reg; // RL10
   assign retry_keep = keep_reg;
   assign running_timer = timer_reg;
   assign timestamp_register = stamp_reg;
   assign irq = irq_reg;

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_enable_gates_bus: assert property (!en |-> !bus_active) // RL1
      else $error("bus active while disabled");
   a_sleep_after_drain: assert property // RL2
      ($rose(sleeping) |-> $past(!tx_pending) && lowpwr)
      else $error("sleep entered with pending transmit");
   a_listen_follows: assert property (listen_mode == (en && // RL3
      mode_reg[cmim_pkg::CMIM_MR_LISTEN]))
      else $error("listen mode mismatch");
   a_overload_cause: assert property (overload_request |-> // RL4
      $past(rx_done && rx_mailbox_is_rx && mode_reg[3]))
      else $error("overload without cause");
   a_ts_capture: assert property (ts_hit |=> // RL5
      stamp_reg == $past(timer_reg))
      else $error("timestamp not captured");
   a_timer_wrap: assert property (en && !frz && !tt_sync && // RL7
      timer_tick && at_max |=> timer_reg == 16'h0000)
      else $error("timer did not wrap");
   a_timer_freeze: assert property (en && frz && at_max && // RL8
      !tt_sync ##1 en |-> at_max)
      else $error("frozen timer moved");
   a_keep_pending: assert property (arb_lost && en && !norep |=> // RL9
      retry_keep != 8'h00 && mailbox_abort_flag == 8'h00)
      else $error("request not kept");
   a_abort_flags: assert property (arb_lost && en && norep |=> // RL10
      mailbox_abort_flag == (8'h01 << $past(arb_mailbox))
      && mailbox_ready_flag == mailbox_abort_flag)
      else $error("abort flags wrong");
   a_ier_sets: assert property (wr_ier && !wr_idr |=> // RL11
      (imr_reg & $past(wbits & cmim_pkg::CMIM_IRQ_BITS))
      == $past(wbits & cmim_pkg::CMIM_IRQ_BITS))
      else $error("mask bit not set");
   a_idr_clears: assert property (wr_idr |=> // RL12
      (imr_reg & $past(wbits)) == 32'h00000000)
      else $error("mask bit not cleared");
   a_mask_stable: assert property (!wr_ier && !wr_idr |=> // RL13
      $stable(imr_reg))
      else $error("mask changed without write");
   a_irq_level: assert property (irq_next |=> irq) // RL17
      else $error("interrupt not raised");
   a_tt_reset: assert property (tt_sync && en |=> // RL18
      timer_reg == 16'h0000)
      else $error("reference receive did not reset timer");
   a_unused_zero: assert property // RL19
      ((imr_reg & ~cmim_pkg::CMIM_IRQ_BITS) == 32'h00000000)
      else $error("unassigned mask bit set");

   c_write_ier: cover property (wr_ier ##[1:4] irq);
   c_sleep: cover property ($rose(sleeping));
   c_abort: cover property (mailbox_abort_flag != 8'h00);
   c_wrap: cover property (ovf_hit && !frz);
endmodule : cmim_ctrl

// ==== tb/cmim_engine_model.sv ====
module cmim_engine_model
(
   input wire logic clk,
   output logic timer_tick,
   output logic sof_seen,
   output logic eof_seen,
   output logic tx_pending,
   output logic rx_done,
   output logic [2:0] rx_mailbox,
   output logic rx_mailbox_is_rx,
   output logic arb_lost,
   output logic [2:0] arb_mailbox,
   output logic [7:0] mailbox_event_bit,
   output logic error_active_source,
   output logic warning_limit_source,
   output logic error_passive_source,
   output logic bus_off_source,
   output logic [4:0] protocol_error_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {timer_tick, sof_seen, eof_seen, tx_pending, rx_done} = 5'h00;
      {rx_mailbox, rx_mailbox_is_rx, arb_lost, arb_mailbox} = 8'h00;
      mailbox_event_bit = 8'h00;
      protocol_error_pulse = 5'h00;
      {error_active_source, warning_limit_source} = 2'h0;
      {error_passive_source, bus_off_source} = 2'h0;
   end
   // tick held high: one count per edge
   task automatic tick(input int n);
      timer_tick <= 1'b1;
      repeat (n) @(posedge clk);
      timer_tick <= 1'b0;
   endtask : tick
   // 1 sof, 2 eof, 3 receive, 4 lost arbitration, 5 event, 6 error
   task automatic fire(input int k, input logic [2:0] mb, input logic rx);
      rx_mailbox <= mb;
      arb_mailbox <= mb;
      rx_mailbox_is_rx <= rx;
      case (k)
         1: sof_seen <= 1'b1;
         2: eof_seen <= 1'b1;
         3: rx_done <= 1'b1;
         4: arb_lost <= 1'b1;
         5: mailbox_event_bit <= 8'h01 << mb;
         default: protocol_error_pulse <= 5'h01 << mb;
      endcase
      @(posedge clk);
      {sof_seen, eof_seen, rx_done, arb_lost} <= 4'h0;
      mailbox_event_bit <= 8'h00;
      protocol_error_pulse <= 5'h00;
      @(posedge clk);
   endtask : fire
   task automatic set_lv(input logic p, input logic [3:0] v);
      tx_pending <= p;
      bus_off_source <= v[3];
      error_passive_source <= v[2];
      warning_limit_source <= v[1];
      error_active_source <= v[0];
      repeat (2) @(posedge clk);
   endtask : set_lv
endmodule : cmim_engine_model

// ==== tb/can_mode_and_irq_mask_tb.sv ====
module can_mode_and_irq_mask_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic timer_tick, sof_seen, eof_seen, tx_pending, rx_done;
   logic rx_mailbox_is_rx, arb_lost, error_active_source;
   logic warning_limit_source, error_passive_source, bus_off_source;
   logic [2:0] rx_mailbox, arb_mailbox;
   logic [7:0] mailbox_event_bit, mailbox_abort_flag, mailbox_ready_flag;
   logic [7:0] retry_keep, abt_seen, rdy_seen, keep_seen;
   logic [4:0] protocol_error_pulse;
   logic bus_active, listen_mode, time_triggered_mode;
   logic mailbox_timestamp_on, overload_request, irq;
   logic [15:0] running_timer, timestamp_register;
   logic [31:0] mask_m, d, seed;
   int fails, compares, ovld_cnt, i;
   cmim_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_tick, .sof_seen,
      .eof_seen, .tx_pending, .rx_done, .rx_mailbox, .rx_mailbox_is_rx,
      .arb_lost, .arb_mailbox, .mailbox_event_bit, .error_active_source,
      .warning_limit_source, .error_passive_source, .bus_off_source,
      .protocol_error_pulse, .bus_active, .listen_mode,
      .time_triggered_mode, .mailbox_timestamp_on, .overload_request,
      .mailbox_abort_flag, .mailbox_ready_flag, .retry_keep,
      .running_timer, .timestamp_register, .irq);
   cmim_engine_model eng (.clk(aclk), .timer_tick, .sof_seen, .eof_seen,
      .tx_pending, .rx_done, .rx_mailbox, .rx_mailbox_is_rx, .arb_lost,
      .arb_mailbox, .mailbox_event_bit, .error_active_source,
      .warning_limit_source, .error_passive_source, .bus_off_source,
      .protocol_error_pulse);
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // pulse monitor samples mid-cycle, clear of the launching edge
   always @(negedge aclk)
   begin
      if (overload_request === 1'b1)
         ovld_cnt++;
      abt_seen |= mailbox_abort_flag;
      rdy_seen |= mailbox_ready_flag;
      keep_seen |= retry_keep;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic finish_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic chk_resp(input string n, input logic [1:0] e,
      input logic [1:0] g);
      chk(n, {30'h0, e}, {30'h0, g});
   endtask : chk_resp
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      logic [1:0] r;
      int n;
      n = 0;
      tb = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!tb)
      begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 1'b0;
         if (tw)
            s_axi_wvalid <= 1'b0;
         n++;
         if (n > 40)
         begin
            fails++;
            finish_test();
         end
      end
      s_axi_bready <= 1'b0;
      if (a == 8'h04)
         mask_m = mask_m | (v & cmim_pkg::CMIM_IRQ_BITS);
      if (a == 8'h08)
         mask_m = mask_m & ~v;
      chk_resp("bresp", (a > 8'h08) ? 2'h2 : 2'h0, r);
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ta, t;
      logic [1:0] r;
      int n;
      n = 0;
      t = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!t)
      begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         t = s_axi_rvalid;
         v = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta)
            s_axi_arvalid <= 1'b0;
         n++;
         if (n > 40)
         begin
            fails++;
            finish_test();
         end
      end
      s_axi_rready <= 1'b0;
      chk_resp("rresp", (a == 8'h14 || a > 8'h1C) ? 2'h2 : 2'h0, r);
      @(posedge aclk);
   endtask : rd
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {fails, compares, ovld_cnt, mask_m} = '0;
      seed = 32'hA4EE;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      {abt_seen, rdy_seen, keep_seen} = 24'h0;
      rd(8'h00, d);
      chk("mode", 32'h0, d);
      rd(8'h0C, d);
      chk("mask", 32'h0, d);
      chk("bus_active", 32'h0, bus_active);
      for (i = 0; i < 6; i++)
      begin
         seed = xs(seed);
         wr(8'h04, seed);
         rd(8'h0C, d);
         chk("mask", mask_m, d);
         seed = xs(seed);
         wr(8'h08, seed);
         rd(8'h0C, d);
         chk("mask", mask_m, d);
      end
      wr(8'h0C, 32'hFFFFFFFF);
      rd(8'h0C, d);
      chk("mask", mask_m, d);
      rd(8'h14, d);
      chk("unmapped", 32'h0, d);
      wr(8'h00, 32'h05);
      rd(8'h00, d);
      chk("mode", 32'h05, d);
      @(negedge aclk);
      chk("bus_active", 32'h1, bus_active);
      chk("listen", 32'h1, listen_mode);
      chk("tt", 32'h0, time_triggered_mode);
      chk("ts_on", 32'h1, mailbox_timestamp_on);
      @(posedge aclk);
      wr(8'h00, 32'h21);
      @(negedge aclk);
      chk("listen", 32'h0, listen_mode);
      chk("tt", 32'h1, time_triggered_mode);
      @(posedge aclk);
      wr(8'h00, 32'h01);
      rd(8'h10, d);
      for (i = 0; i < 8; i++)
      begin
         eng.fire(5, i[2:0], 1'b0);
         rd(8'h10, d);
         chk("status mb", 32'h1 << i, d & 32'hFF);
      end
      for (i = 0; i < 5; i++)
      begin
         eng.fire(6, i[2:0], 1'b0);
         rd(8'h10, d);
         chk("status err", 32'h01000000 << i, d & 32'h1F000000);
      end
      for (i = 0; i < 4; i++)
      begin
         eng.set_lv(1'b0, 4'h1 << i);
         rd(8'h10, d);
         chk("status bus", 32'h10000 << i, d & 32'hF0000);
      end
      eng.set_lv(1'b0, 4'h0);
      wr(8'h08, 32'hFFFFFFFF);
      wr(8'h04, 32'h01);
      rd(8'h10, d);
      eng.fire(5, 3'h0, 1'b0);
      @(negedge aclk);
      chk("irq", 32'h1, irq);
      @(posedge aclk);
      rd(8'h10, d);
      @(negedge aclk);
      chk("irq", 32'h0, irq);
      @(posedge aclk);
      wr(8'h08, 32'h01);
      eng.fire(5, 3'h0, 1'b0);
      @(negedge aclk);
      chk("irq", 32'h0, irq);
      @(posedge aclk);
      wr(8'h00, 32'h09);
      eng.fire(3, 3'h2, 1'b1);
      chk("overload", 32'h1, ovld_cnt);
      eng.fire(3, 3'h2, 1'b0);
      wr(8'h00, 32'h81);
      eng.fire(3, 3'h2, 1'b1);
      chk("overload", 32'h1, ovld_cnt);
      eng.fire(4, 3'h3, 1'b0);
      chk("abort", 32'h08, abt_seen);
      chk("ready", 32'h08, rdy_seen);
      wr(8'h00, 32'h01);
      eng.fire(4, 3'h5, 1'b0);
      chk("keep", 32'h20, keep_seen);
      chk("abort", 32'h08, abt_seen);
      eng.tick(5);
      eng.fire(1, 3'h0, 1'b0);
      eng.fire(2, 3'h0, 1'b0);
      chk("stamp", 32'h5, timestamp_register);
      eng.tick(2);
      wr(8'h00, 32'h11);
      eng.fire(1, 3'h0, 1'b0);
      chk("stamp", 32'h5, timestamp_register);
      eng.fire(2, 3'h0, 1'b0);
      rd(8'h1C, d);
      chk("stamp", 32'h7, d);
      wr(8'h00, 32'h61);
      eng.tick(65540);
      rd(8'h18, d);
      chk("timer", 32'hFFFF, d);
      wr(8'h00, 32'h21);
      rd(8'h10, d);
      eng.tick(1);
      @(negedge aclk);
      chk("timer", 32'h0, running_timer);
      @(posedge aclk);
      rd(8'h10, d);
      chk("overflow", 32'h00400000, d & 32'h00400000);
      eng.tick(3);
      eng.fire(3, 3'h7, 1'b1);
      chk("timer", 32'h0, running_timer);
      eng.set_lv(1'b1, 4'h0);
      wr(8'h00, 32'h03);
      @(negedge aclk);
      chk("bus_active", 32'h1, bus_active);
      @(posedge aclk);
      eng.set_lv(1'b0, 4'h0);
      @(negedge aclk);
      chk("bus_active", 32'h0, bus_active);
      @(posedge aclk);
      finish_test();
   end
endmodule : can_mode_and_irq_mask_tb
